// ---- ctm_timer.sv ----
// Compact timer output compare block with APB register slave
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module ctm_timer (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timer output pin
   output logic timer_output_pin
);
   import ctm_pkg::*;

   logic [7:0] ctrl0_ff, nxt_ctrl0;
   ctm_ctrl_s ctrl_ff, nxt_ctrl;
   logic [15:0] cmpa_ff, nxt_cmpa;
   logic [7:0] period_ff, nxt_period;
   logic [7:0] buf_ff, nxt_buf;
   logic on_d_ff;
   logic pin_ff, nxt_pin;
   logic out_ff, nxt_out;
   logic [31:0] rdata_ff, nxt_rdata;
   logic ready_ff, nxt_ready;
   logic err_ff, nxt_err;
   ctm_bus_e bus_ff, nxt_bus;
   logic [15:0] count;
   logic tick;
   logic counter_on, on_rise;
   logic match_a, match_p, clr;
   logic [15:0] period_full;
   logic duty_on, pwm_level;
   logic access, wr, rd, addr_ok;

   // Counter-on and its edge
   assign counter_on = ctrl0_ff[CTM_BIT_ON];
   assign on_rise = counter_on & ~on_d_ff;

   // Comparators act on the count about to advance
   assign match_a = (count == cmpa_ff);
   // Last count before the upper byte reaches the period value, so N gives N*256 clocks
   assign match_p = (count[15:8] == (period_ff - 8'h01)) && (count[7:0] == CTM_CNT_MAX[7:0]);
   // Period byte times 256, the swapped duty length
   assign period_full = {period_ff, CTM_RST_BYTE};

   // Clear source selection; PWM uses the swap bit, not the clear bit
   always_comb begin
      clr = 1'b0;
      if (ctrl_ff.operating_mode_sel == CTM_MODE_PWM) begin
         if (ctrl_ff.period_duty_swap) begin
            clr = match_a;
         end else begin
            clr = (period_ff != CTM_RST_BYTE) && match_p;
         end
      end else if (ctrl_ff.clear_source_sel) begin
         clr = match_a;
      end else begin
         // Zero period leaves wrap at full count as the clear
         clr = (period_ff != CTM_RST_BYTE) && match_p;
      end
   end

   // PWM duty: count below duty register means active
   always_comb begin
      if (ctrl_ff.period_duty_swap) begin
         duty_on = (period_ff == CTM_RST_BYTE) ? 1'b1 : (count < period_full);
      end else begin
         duty_on = (count < cmpa_ff);
      end
      // Active level from initial-level bit
      pwm_level = duty_on ? ctrl_ff.output_initial_level : ~ctrl_ff.output_initial_level;
   end

   ctm_counter #(
      .WIDTH(16),
      .DIV(CTM_TICK_DIV)
   ) u_counter (
      .pclk(pclk),
      .presetn(presetn),
      .run(counter_on),
      .restart(on_rise),
      .clear(clr),
      .count_ff(count),
      .tick_ff(tick)
   );

   // Pin state machine; compare actions apply on a ticked A match
   always_comb begin
      nxt_pin = pin_ff;
      case (ctrl_ff.operating_mode_sel)
         CTM_MODE_CMP: begin
            if (on_rise) begin
               nxt_pin = ctrl_ff.output_initial_level;
            end else if (!counter_on) begin
               // Stopped: pin keeps whatever the last match left
               nxt_pin = pin_ff;
            end else if (tick && match_a) begin
               case (ctrl_ff.output_action_sel)
                  CTM_ACT_01: nxt_pin = 1'b0;
                  CTM_ACT_10: nxt_pin = 1'b1;
                  CTM_ACT_11: nxt_pin = ~pin_ff;
                  default: nxt_pin = pin_ff;
               endcase
            end
         end
         CTM_MODE_PWM: begin
            case (ctrl_ff.output_action_sel)
               CTM_ACT_00: nxt_pin = ~ctrl_ff.output_initial_level;
               CTM_ACT_01: nxt_pin = ctrl_ff.output_initial_level;
               CTM_ACT_10: nxt_pin = counter_on ? pwm_level : ~ctrl_ff.output_initial_level;
               default: nxt_pin = pin_ff; // Undefined code holds level
            endcase
         end
         default: nxt_pin = 1'b0;
      endcase
      // Invert only in compare and PWM modes; timer and undefined modes drive the output low
      if (ctrl_ff.operating_mode_sel == CTM_MODE_TMR || ctrl_ff.operating_mode_sel == CTM_MODE_UNDEF) begin
         nxt_out = 1'b0;
      end else begin
         nxt_out = nxt_pin ^ ctrl_ff.output_invert;
      end
   end

   // Pin registers; pin level resets low, compare mode loads the initial bit at each start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_ff <= 1'b0;
         out_ff <= 1'b0;
         on_d_ff <= 1'b0;
      end else begin
         pin_ff <= nxt_pin;
         out_ff <= nxt_out;
         on_d_ff <= counter_on;
      end
   end
   assign timer_output_pin = out_ff;

   // APB decode
   assign access = psel & penable & ~ready_ff;
   assign wr = access & pwrite;
   assign rd = access & ~pwrite;
   always_comb begin
      case (paddr)
         CTM_ADDR_CTRL0, CTM_ADDR_CTRL1, CTM_ADDR_CNT_LO, CTM_ADDR_CNT_HI,
         CTM_ADDR_CMPA_LO, CTM_ADDR_CMPA_HI, CTM_ADDR_PERIOD, CTM_ADDR_STATUS: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // Register writes and read side effects
   always_comb begin
      nxt_ctrl0 = ctrl0_ff;
      nxt_ctrl = ctrl_ff;
      nxt_cmpa = cmpa_ff;
      nxt_period = period_ff;
      nxt_buf = buf_ff;
      nxt_rdata = rdata_ff;
      nxt_err = 1'b0;
      if (wr && addr_ok) begin
         case (paddr)
            CTM_ADDR_CTRL0: nxt_ctrl0 = {4'h0, pwdata[CTM_BIT_ON], 3'h0};
            CTM_ADDR_CTRL1: nxt_ctrl = ctm_ctrl_s'(pwdata[7:0]);
            CTM_ADDR_CMPA_LO: nxt_buf = pwdata[7:0];
            CTM_ADDR_CMPA_HI: nxt_cmpa = {pwdata[7:0], buf_ff};
            CTM_ADDR_PERIOD: nxt_period = pwdata[7:0];
            default: nxt_err = 1'b0;
         endcase
      end
      if (rd) begin
         nxt_rdata = 32'h0000_0000;
         case (paddr)
            CTM_ADDR_CTRL0: nxt_rdata = {24'h00_0000, ctrl0_ff};
            CTM_ADDR_CTRL1: nxt_rdata = {24'h00_0000, ctrl_ff};
            CTM_ADDR_CNT_LO: nxt_rdata = {24'h00_0000, buf_ff};
            CTM_ADDR_CNT_HI: begin
               nxt_rdata = {24'h00_0000, count[15:8]};
               nxt_buf = count[7:0];
            end
            CTM_ADDR_CMPA_LO: nxt_rdata = {24'h00_0000, buf_ff};
            CTM_ADDR_CMPA_HI: begin
               nxt_rdata = {24'h00_0000, cmpa_ff[15:8]};
               nxt_buf = cmpa_ff[7:0];
            end
            CTM_ADDR_PERIOD: nxt_rdata = {24'h00_0000, period_ff};
            CTM_ADDR_STATUS: nxt_rdata = {30'h0000_0000, timer_output_pin, counter_on};
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
      if (access && !addr_ok) begin
         nxt_err = 1'b1;
      end
   end

   // Bus handshake: one wait cycle, then pready for one cycle
   always_comb begin
      nxt_bus = bus_ff;
      nxt_ready = 1'b0;
      case (bus_ff)
         CTM_BUS_IDLE: begin
            if (access) begin
               nxt_bus = CTM_BUS_DONE;
               nxt_ready = 1'b1;
            end
         end
         CTM_BUS_DONE: nxt_bus = CTM_BUS_IDLE;
         default: nxt_bus = CTM_BUS_IDLE;
      endcase
   end

   // Register file and bus registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl0_ff <= CTM_RST_BYTE;
         ctrl_ff <= ctm_ctrl_s'(CTM_RST_BYTE);
         cmpa_ff <= CTM_RST_WORD;
         period_ff <= CTM_RST_BYTE;
         buf_ff <= CTM_RST_BYTE;
         rdata_ff <= 32'h0000_0000;
         ready_ff <= 1'b0;
         err_ff <= 1'b0;
         bus_ff <= CTM_BUS_IDLE;
      end else begin
         ctrl0_ff <= nxt_ctrl0;
         ctrl_ff <= nxt_ctrl;
         cmpa_ff <= nxt_cmpa;
         period_ff <= nxt_period;
         buf_ff <= nxt_buf;
         rdata_ff <= nxt_rdata;
         ready_ff <= nxt_ready;
         err_ff <= nxt_err;
         bus_ff <= nxt_bus;
      end
   end
   assign prdata = rdata_ff;
   assign pready = ready_ff;
   assign pslverr = err_ff;
endmodule : ctm_timer
`default_nettype wire

// ---- ctm_pkg.sv ----
// Package for the compact timer output compare block
package ctm_pkg;
   // Register byte addresses (APB word aligned)
   localparam logic [7:0] CTM_ADDR_CTRL0 = 8'h00;
   localparam logic [7:0] CTM_ADDR_CTRL1 = 8'h04;
   localparam logic [7:0] CTM_ADDR_CNT_LO = 8'h08;
   localparam logic [7:0] CTM_ADDR_CNT_HI = 8'h0C;
   localparam logic [7:0] CTM_ADDR_CMPA_LO = 8'h10;
   localparam logic [7:0] CTM_ADDR_CMPA_HI = 8'h14;
   localparam logic [7:0] CTM_ADDR_PERIOD = 8'h18;
   localparam logic [7:0] CTM_ADDR_STATUS = 8'h1C;
   // Field positions in timer_ctrl_second
   localparam int CTM_BIT_MODE_HI = 7;
   localparam int CTM_BIT_MODE_LO = 6;
   localparam int CTM_BIT_ACT_HI = 5;
   localparam int CTM_BIT_ACT_LO = 4;
   localparam int CTM_BIT_INIT = 3;
   localparam int CTM_BIT_INV = 2;
   localparam int CTM_BIT_SWAP = 1;
   localparam int CTM_BIT_CLR = 0;
   // Field position of counter_on in the first control register
   localparam int CTM_BIT_ON = 3;
   // Reset values and counter constants
   localparam logic [7:0] CTM_RST_BYTE = 8'h00;
   localparam logic [15:0] CTM_RST_WORD = 16'h0000;
   localparam logic [15:0] CTM_CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CTM_CNT_ONE = 16'h0001;
   // Timer clock enable divider, cycles of pclk per timer tick
   localparam int CTM_TICK_DIV = 1;
   // Operating modes
   typedef enum logic [1:0] {
      CTM_MODE_CMP = 2'b00,
      CTM_MODE_UNDEF = 2'b01,
      CTM_MODE_PWM = 2'b10,
      CTM_MODE_TMR = 2'b11
   } ctm_mode_e;
   // Output actions
   localparam logic [1:0] CTM_ACT_00 = 2'b00;
   localparam logic [1:0] CTM_ACT_01 = 2'b01;
   localparam logic [1:0] CTM_ACT_10 = 2'b10;
   localparam logic [1:0] CTM_ACT_11 = 2'b11;
   // Second control register fields
   typedef struct packed {
      ctm_mode_e operating_mode_sel;
      logic [1:0] output_action_sel;
      logic output_initial_level;
      logic output_invert;
      logic period_duty_swap;
      logic clear_source_sel;
   } ctm_ctrl_s;
   // Bus slave states
   typedef enum logic [1:0] {
      CTM_BUS_IDLE = 2'b01,
      CTM_BUS_DONE = 2'b10
   } ctm_bus_e;
endpackage : ctm_pkg

// ---- ctm_counter.sv ----
// Timer counter with enable divider, clear and overflow
`timescale 1ns/10ps
`default_nettype none
module ctm_counter #(
   parameter int WIDTH = 16,
   parameter int DIV = ctm_pkg::CTM_TICK_DIV
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic run,
   input wire logic restart,
   input wire logic clear,
   // State
   output logic [WIDTH-1:0] count_ff,
   output logic tick_ff
);
   import ctm_pkg::*;
   logic [7:0] div_ff;
   logic [7:0] nxt_div;
   logic [WIDTH-1:0] nxt_count;
   logic nxt_tick;

   // Divider gives one-cycle tick enables; counter moves on tick only, except restart zeroes it at once
   always_comb begin
      nxt_div = div_ff;
      nxt_tick = 1'b0;
      nxt_count = count_ff;
      if (run) begin
         if (div_ff == 8'(DIV - 1)) begin
            nxt_div = 8'h00;
            nxt_tick = 1'b1;
         end else begin
            nxt_div = div_ff + 8'h01;
         end
      end
      if (restart) begin
         nxt_count = '0;
         nxt_div = 8'h00;
      end else if (run && nxt_tick) begin
         // Clear wins over increment; overflow wraps naturally
         nxt_count = clear ? '0 : count_ff + WIDTH'(1);
      end
   end

   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= 8'h00;
         tick_ff <= 1'b0;
         count_ff <= '0;
      end else begin
         div_ff <= nxt_div;
         tick_ff <= nxt_tick;
         count_ff <= nxt_count;
      end
   end
endmodule : ctm_counter
`default_nettype wire

// ---- ctm_timer_assertions.sv ----
// Checker for the compact timer register and pin behaviour
`timescale 1ns/10ps
`default_nettype none
module ctm_timer_assertions (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pin
   input wire logic timer_output_pin
);
   import ctm_pkg::*;
   logic wr, rd, on_ff, bv_ff;
   logic [7:0] ctrl_ff, per_ff, buf_ff;
   logic [15:0] cmpa_ff;
   ctm_ctrl_s cs;
   // Completed transfers only
   assign wr = psel && penable && pready && pwrite;
   assign rd = psel && penable && pready && !pwrite;
   assign cs = ctrl_ff;
   // Shadow of software writes; a counter read spoils the shared buffer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {on_ff, bv_ff, ctrl_ff, per_ff, buf_ff, cmpa_ff} <= '0;
      end else if (wr) begin
         case (paddr)
            CTM_ADDR_CTRL0: on_ff <= pwdata[CTM_BIT_ON];
            CTM_ADDR_CTRL1: ctrl_ff <= pwdata[7:0];
            CTM_ADDR_PERIOD: per_ff <= pwdata[7:0];
            CTM_ADDR_CMPA_LO: {bv_ff, buf_ff} <= {1'b1, pwdata[7:0]};
            CTM_ADDR_CMPA_HI: cmpa_ff <= {pwdata[7:0], buf_ff};
            default: ;
         endcase
      end else if (rd && paddr == CTM_ADDR_CMPA_HI) begin
         {bv_ff, buf_ff} <= {1'b1, cmpa_ff[7:0]};
      end else if (rd && paddr == CTM_ADDR_CNT_HI) begin
         bv_ff <= 1'b0;
      end
   end
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_on_rise;
      wr && paddr == CTM_ADDR_CTRL0 && pwdata[CTM_BIT_ON] && !on_ff;
   endsequence
   sequence s_cmp_armed;
      cs.operating_mode_sel == CTM_MODE_CMP && cmpa_ff > 16'h0008;
   endsequence
   a_on_restores_init: assert property (s_on_rise and s_cmp_armed |=>
      timer_output_pin == (cs.output_initial_level ^ cs.output_invert)) else $error("Pin not at initial level");
   a_timer_pin_low: assert property (
      cs.operating_mode_sel == CTM_MODE_TMR && $stable(ctrl_ff) |-> !timer_output_pin) else $error("Pin in timer mode");
   a_pwm_forced_level: assert property (
      cs.operating_mode_sel == CTM_MODE_PWM && !cs.output_action_sel[1] && $stable(ctrl_ff) |->
      timer_output_pin == ((cs.output_action_sel[0] ~^ cs.output_initial_level) ^ cs.output_invert))
      else $error("Forced PWM level wrong");
   a_ctrl_read_back: assert property (
      rd && paddr == CTM_ADDR_CTRL1 |-> prdata[7:0] == ctrl_ff) else $error("Control readback wrong");
   a_period_read_back: assert property (
      rd && paddr == CTM_ADDR_PERIOD |-> prdata[7:0] == per_ff) else $error("Period readback wrong");
   a_cmpa_high_read: assert property (
      rd && paddr == CTM_ADDR_CMPA_HI |-> prdata[7:0] == cmpa_ff[15:8]) else $error("Compare high wrong");
   a_low_from_buffer: assert property (
      rd && paddr == CTM_ADDR_CMPA_LO && bv_ff |-> prdata[7:0] == buf_ff) else $error("Low byte not buffered");
   a_status_counter_on: assert property (
      rd && paddr == CTM_ADDR_STATUS |-> prdata[0] == on_ff) else $error("Status run bit wrong");
endmodule : ctm_timer_assertions
bind ctm_timer ctm_timer_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .timer_output_pin(timer_output_pin));
`default_nettype wire

// ---- ctm_load.sv ----
// Load on the timer output pin, counts cycles the pin is high
`timescale 1ns/10ps
`default_nettype none
module ctm_load (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pin and measurement window
   input wire logic pin,
   input wire logic restart,
   output logic [15:0] high_ff
);
   logic [15:0] nxt_high;
   // High time, restarted for each window
   always_comb begin
      nxt_high = restart ? 16'h0000 : high_ff + {15'h0000, pin};
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_ff <= 16'h0000;
      end else begin
         high_ff <= nxt_high;
      end
   end
endmodule : ctm_load
`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench for the compact timer block
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import ctm_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, restart = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, pin, e;
   logic [15:0] high_cnt;
   logic [7:0] v, v2;
   int fails = 0, checked = 0, cycles = 0;
   ctm_ctrl_s c;
   ctm_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_output_pin(pin));
   ctm_load i_load (.pclk(pclk), .presetn(presetn), .pin(pin), .restart(restart), .high_ff(high_cnt));
   // 40 MHz clock and hang guard
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         report_and_stop();
      end
   end
   task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
      checked++;
      if (g !== x) begin
         fails++;
         $display("ERROR %s exp %h got %h", n, x, g);
      end
   endtask : chk
   // One APB transfer, held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      // No local limit: only the bench cycle guard ends a stuck wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      v = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic t_reset;
      apb(1'b0, CTM_ADDR_CNT_HI, 8'h00); chk("cnt_hi", 8'h00, v);
      apb(1'b0, CTM_ADDR_CMPA_HI, 8'h00); chk("cmpa_hi", 8'h00, v);
      apb(1'b0, CTM_ADDR_PERIOD, 8'h00); chk("period", 8'h00, v);
      apb(1'b0, 8'h20, 8'h00); chk("pslverr", 1'b1, e);
      apb(1'b1, CTM_ADDR_CNT_HI, 8'h55);
      apb(1'b0, CTM_ADDR_CNT_HI, 8'h00); chk("cnt_ro", 8'h00, v);
   endtask : t_reset
   // Low write must wait for the high write
   task automatic t_cmpa;
      apb(1'b1, CTM_ADDR_CMPA_LO, 8'h34);
      apb(1'b1, CTM_ADDR_CMPA_HI, 8'h12);
      apb(1'b1, CTM_ADDR_CMPA_LO, 8'h56);
      apb(1'b0, CTM_ADDR_CMPA_HI, 8'h00); chk("cmpa_hi", 8'h12, v);
      apb(1'b0, CTM_ADDR_CMPA_LO, 8'h00); chk("cmpa_lo", 8'h34, v);
      apb(1'b1, CTM_ADDR_PERIOD, 8'hA5);
      apb(1'b0, CTM_ADDR_PERIOD, 8'h00); chk("period", 8'hA5, v);
   endtask : t_cmpa
   // Every action with both initial levels, one match at count 0x40
   task automatic t_compare;
      apb(1'b1, CTM_ADDR_CMPA_LO, 8'h40);
      apb(1'b1, CTM_ADDR_CMPA_HI, 8'h00);
      for (int k = 0; k < 8; k++) begin
         c = '0;
         c.output_action_sel = k[2:1];
         c.output_initial_level = k[0];
         c.clear_source_sel = 1'b1;
         apb(1'b1, CTM_ADDR_CTRL1, c);
         apb(1'b1, CTM_ADDR_CTRL0, 8'h08);
         repeat (2) @(posedge pclk);
         chk("pin_init", k[0], pin);
         repeat (80) @(posedge pclk);
         chk("pin_match", k[2] ? (k[1] ? !k[0] : 1'b1) : (k[1] ? 1'b0 : k[0]), pin);
         apb(1'b1, CTM_ADDR_CTRL0, 8'h00);
      end
   endtask : t_compare
   // Period 256, duty 0x40, clear source set but ignored
   task automatic t_pwm;
      apb(1'b1, CTM_ADDR_PERIOD, 8'h01);
      for (int k = 0; k < 3; k++) begin
         c = '0;
         c.operating_mode_sel = CTM_MODE_PWM;
         c.output_action_sel = CTM_ACT_10;
         c.output_initial_level = (k != 1);
         c.output_invert = (k == 2);
         c.clear_source_sel = 1'b1;
         apb(1'b1, CTM_ADDR_CTRL1, c);
         apb(1'b1, CTM_ADDR_CTRL0, 8'h08);
         repeat (300) @(posedge pclk);
         restart <= 1'b1;
         @(posedge pclk);
         restart <= 1'b0;
         repeat (256) @(posedge pclk);
         #1;
         chk("pwm_high", (k == 0) ? 16'h0040 : 16'h00C0, high_cnt);
         apb(1'b1, CTM_ADDR_CTRL0, 8'h00);
      end
      for (int k = 0; k < 2; k++) begin
         c.output_action_sel = k[1:0];
         c.output_invert = 1'b0;
         apb(1'b1, CTM_ADDR_CTRL1, c);
         repeat (3) @(posedge pclk);
         chk("pwm_forced", k[0], pin);
      end
      // Swapped roles: compare-A 0x01FF gives a 512 clock period, period byte 1 a 256 clock duty
      apb(1'b1, CTM_ADDR_CMPA_LO, 8'hFF);
      apb(1'b1, CTM_ADDR_CMPA_HI, 8'h01);
      c = '0;
      c.operating_mode_sel = CTM_MODE_PWM;
      c.output_action_sel = CTM_ACT_10;
      c.output_initial_level = 1'b1;
      c.period_duty_swap = 1'b1;
      apb(1'b1, CTM_ADDR_CTRL1, c);
      apb(1'b1, CTM_ADDR_CTRL0, 8'h08);
      repeat (300) @(posedge pclk);
      restart <= 1'b1;
      @(posedge pclk);
      restart <= 1'b0;
      repeat (512) @(posedge pclk);
      #1;
      chk("pwm_swap_high", 16'h0100, high_cnt);
      apb(1'b1, CTM_ADDR_CTRL0, 8'h00);
      apb(1'b1, CTM_ADDR_CMPA_LO, 8'h40);
      apb(1'b1, CTM_ADDR_CMPA_HI, 8'h00);
   endtask : t_pwm
   // Timer mode: pin idle, period and compare-A clears, run and hold
   task automatic t_timer;
      c = '0;
      c.operating_mode_sel = CTM_MODE_TMR;
      c.output_initial_level = 1'b1;
      c.output_invert = 1'b1;
      apb(1'b1, CTM_ADDR_CTRL1, c);
      apb(1'b0, CTM_ADDR_CTRL1, 8'h00); chk("ctrl1", c, v);
      apb(1'b1, CTM_ADDR_CTRL0, 8'h08);
      apb(1'b0, CTM_ADDR_STATUS, 8'h00); chk("status_on", 1'b1, v[0]);
      chk("tmr_pin", 1'b0, pin);
      repeat (1000) @(posedge pclk);
      apb(1'b1, CTM_ADDR_CTRL0, 8'h00);
      apb(1'b0, CTM_ADDR_CNT_HI, 8'h00); chk("cnt_hi_bound", 8'h00, v);
      v2 = v;
      apb(1'b0, CTM_ADDR_CNT_HI, 8'h00); chk("cnt_held", v2, v);
      apb(1'b1, CTM_ADDR_CTRL0, 8'h08);
      apb(1'b1, CTM_ADDR_CTRL0, 8'h00);
      apb(1'b0, CTM_ADDR_CNT_HI, 8'h00); chk("cnt_zeroed", 8'h00, v);
      apb(1'b0, CTM_ADDR_CNT_LO, 8'h00); chk("cnt_lo_small", 1'b1, v <= 8'h08);
      c.clear_source_sel = 1'b1;
      apb(1'b1, CTM_ADDR_CTRL1, c);
      apb(1'b1, CTM_ADDR_CTRL0, 8'h08);
      repeat (500) @(posedge pclk);
      apb(1'b1, CTM_ADDR_CTRL0, 8'h00);
      apb(1'b0, CTM_ADDR_CNT_HI, 8'h00); chk("clr_a_hi", 8'h00, v);
      apb(1'b0, CTM_ADDR_CNT_LO, 8'h00); chk("clr_a_lo", 1'b1, v <= 8'h40);
      // Zero period: no clear at 256, counter runs on towards overflow
      c.clear_source_sel = 1'b0;
      apb(1'b1, CTM_ADDR_CTRL1, c);
      apb(1'b1, CTM_ADDR_PERIOD, 8'h00);
      apb(1'b1, CTM_ADDR_CTRL0, 8'h08);
      repeat (600) @(posedge pclk);
      apb(1'b1, CTM_ADDR_CTRL0, 8'h00);
      apb(1'b0, CTM_ADDR_CNT_HI, 8'h00); chk("ovf_cnt_hi", 8'h02, v);
   endtask : t_timer
   task automatic report_and_stop;
      if (fails == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   // Reset for ten cycles, then each scenario in turn
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_cmpa();
      t_compare();
      t_pwm();
      t_timer();
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
